// ==== hdl/isrp_port.sv ====
// Two-wire target port with register pointer, link logic on the link clock
// Behaviour
// - Reads of hold high bytes keep pointer
// - Invalid write address: NACK, pointer still advances
// - Valid address again: acknowledge and store
// - Page writes wrap across whole address space
// - SDA steady while SCL high; else condition
// - START is SDA fall with SCL high
// - STOP is SDA rise with SCL high
// - Eight data bits then one acknowledge bit
// - No limit on bytes per transaction
// - Acknowledge holds SDA low through SCL high
// - Controller NACK ends read; SDA released
// - All bytes shifted most significant bit first
// - Respond only to the fixed target address
// - Direction low: receive mode, acknowledge address
// - First written byte loads pointer, ACK if valid
// - Invalid-address data discarded, pointer always increments
// - Direction high: acknowledge, transmit from pointer
// - Read without pointer write uses last pointer
// - Repeated START begins a fresh address phase
// - Filter out spikes shorter than 50 ns
// - Invalid-address reads return zeros, pointer increments
// - Sequential reads wrap across the address space
`timescale 1ns/1ns
`default_nettype none

module isrp_port
	import isrp_pkg::*;
(
	// System clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Link clock
	input  wire logic       lclk,
	// Bus pins; SDA is open drain, enable high pulls low
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// Register write side
	output logic            reg_wr_en,
	output logic [7:0]      reg_wr_addr,
	output logic [7:0]      reg_wr_data,
	// Register read side
	output logic            reg_rd_en,
	output logic [7:0]      reg_rd_addr,
	input  wire logic [7:0] reg_rd_data
);

	logic        mrst_s1_r, mrst_n_r, lrst_s1_r, lrst_n_r;
	logic [1:0]  pin_s1_r, pin_s2_r, pin_f_r, pin_q_r;
	logic [3:0]  filt_cnt_r [1:0];
	logic        scl_f, sda_f, rise, fall, start_c, stop_c, byte_end;
	isrp_state_t state_r;
	logic [3:0]  bit_cnt_r;
	logic [7:0]  shreg_r, ptr_r, wr_addr_r, wr_data_r, rd_addr_r, rd_data_r;
	logic        first_r, rw_r, oe_r, wr_tgl_r, rd_tgl_r, rd_busy_r, rd_pend_r, ack_tgl_r;
	logic        ack_s1_r, ack_s2_r, ack_q_r, ack_evt;
	logic        wr_s1_r, wr_s2_r, wr_q_r, rq_s1_r, rq_s2_r, rq_q_r;
	logic        adv_wr, adv_rd;

	// Reset release, one synchroniser per domain
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			mrst_s1_r <= 1'b0;
			mrst_n_r  <= 1'b0;
		end
		else
		begin
			mrst_s1_r <= 1'b1;
			mrst_n_r  <= mrst_s1_r;
		end

	always_ff @(posedge lclk or negedge rst_n)
		if (!rst_n)
		begin
			lrst_s1_r <= 1'b0;
			lrst_n_r  <= 1'b0;
		end
		else
		begin
			lrst_s1_r <= 1'b1;
			lrst_n_r  <= lrst_s1_r;
		end

	// Pin synchroniser and spike filter, bit 0 SCL and bit 1 SDA
	// An idle bus reads high, so the filter resets to high
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pin
			always_ff @(posedge lclk or negedge lrst_n_r)
				if (!lrst_n_r)
				begin
					pin_s1_r[gi]   <= 1'b1;
					pin_s2_r[gi]   <= 1'b1;
					pin_f_r[gi]    <= 1'b1;
					pin_q_r[gi]    <= 1'b1;
					filt_cnt_r[gi] <= 4'h0;
				end
				else
				begin
					pin_s1_r[gi] <= (gi == 0) ? scl_i : sda_i;
					pin_s2_r[gi] <= pin_s1_r[gi];
					pin_q_r[gi]  <= pin_f_r[gi];
					if (pin_s2_r[gi] == pin_f_r[gi])
						filt_cnt_r[gi] <= 4'h0;
					else if (filt_cnt_r[gi] == 4'(FILT_CYC - 1))
					begin
						pin_f_r[gi]    <= pin_s2_r[gi];
						filt_cnt_r[gi] <= 4'h0;
					end
					else
						filt_cnt_r[gi] <= filt_cnt_r[gi] + 4'h1;
				end
		end
	endgenerate

	assign scl_f    = pin_f_r[0];
	assign sda_f    = pin_f_r[1];
	assign rise     = scl_f & ~pin_q_r[0];
	assign fall     = ~scl_f & pin_q_r[0];
	assign start_c  = scl_f & pin_q_r[0] & pin_q_r[1] & ~sda_f;
	assign stop_c   = scl_f & pin_q_r[0] & ~pin_q_r[1] & sda_f;
	assign byte_end = fall && bit_cnt_r == BYTE_BITS;
	assign adv_wr   = state_r == ST_WBYTE && byte_end && !first_r && !start_c && !stop_c;
	assign adv_rd   = state_r == ST_RBYTE && byte_end && !isrp_hold(ptr_r) && !start_c && !stop_c;

	// Read answer arriving from the system side
	always_ff @(posedge lclk or negedge lrst_n_r)
		if (!lrst_n_r)
		begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_q_r  <= 1'b0;
		end
		else
		begin
			ack_s1_r <= ack_tgl_r;
			ack_s2_r <= ack_s1_r;
			ack_q_r  <= ack_s2_r;
		end

	assign ack_evt = ack_s2_r ^ ack_q_r;

	// Protocol sequencer; no byte count limit, only START, STOP, a foreign address or a controller NACK end it
	always_ff @(posedge lclk or negedge lrst_n_r)
		if (!lrst_n_r)
		begin
			state_r   <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shreg_r   <= BYTE_RST;
			first_r   <= 1'b0;
			rw_r      <= DIR_WRITE;
			oe_r      <= 1'b0;
		end
		else if (start_c)
		begin
			state_r   <= ST_ADDR;
			bit_cnt_r <= 4'h0;
			first_r   <= 1'b1;
			oe_r      <= 1'b0;
		end
		else if (stop_c)
		begin
			state_r <= ST_IDLE;
			oe_r    <= 1'b0;
		end
		else
			unique case (state_r)
				ST_IDLE:
					oe_r <= 1'b0;
				ST_ADDR, ST_WBYTE:
					if (rise && bit_cnt_r < BYTE_BITS)
					begin
						shreg_r   <= {shreg_r[6:0], sda_f};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					else if (byte_end)
					begin
						bit_cnt_r <= 4'h0;
						if (state_r == ST_ADDR)
						begin
							if (shreg_r[7:1] == DEV_ADDR)
							begin
								state_r <= ST_AACK;
								oe_r    <= 1'b1;
								rw_r    <= shreg_r[0];
							end
							else
								state_r <= ST_IDLE;
						end
						else
						begin
							state_r <= ST_WACK;
							first_r <= 1'b0;
							oe_r    <= first_r ? isrp_valid(shreg_r) : isrp_valid(ptr_r);
						end
					end
				ST_AACK, ST_WACK:
					if (fall)
					begin
						oe_r    <= 1'b0;
						state_r <= (state_r == ST_AACK && rw_r == DIR_READ) ? ST_FETCH : ST_WBYTE;
					end
				ST_FETCH:
					if (rd_busy_r && ack_evt)
					begin
						shreg_r   <= isrp_valid(rd_addr_r) ? rd_data_r : BYTE_RST;
						oe_r      <= isrp_valid(rd_addr_r) ? ~rd_data_r[MSB_POS] : 1'b1;
						bit_cnt_r <= 4'h1;
						state_r   <= ST_RBYTE;
					end
				ST_RBYTE:
					if (byte_end)
					begin
						oe_r      <= 1'b0;
						bit_cnt_r <= 4'h0;
						state_r   <= ST_RACK;
					end
					else if (fall)
					begin
						shreg_r   <= {shreg_r[6:0], 1'b0};
						oe_r      <= ~shreg_r[MSB_POS - 1];
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				ST_RACK:
					if (rise)
					begin
						rw_r <= sda_f;
						if (sda_f)
							state_r <= ST_IDLE;
					end
					else if (fall)
						state_r <= ST_FETCH;
			endcase

	// Address pointer, kept across transactions; 8-bit add wraps
	always_ff @(posedge lclk or negedge lrst_n_r)
		if (!lrst_n_r)
			ptr_r <= PTR_RST;
		else if (state_r == ST_WBYTE && byte_end && first_r && !start_c && !stop_c)
			ptr_r <= shreg_r;
		else if (adv_wr || adv_rd)
			ptr_r <= ptr_r + 8'h01;

	// Write hand-off; fields stay put for a whole byte time so the toggle may cross alone
	always_ff @(posedge lclk or negedge lrst_n_r)
		if (!lrst_n_r)
		begin
			wr_tgl_r  <= 1'b0;
			wr_addr_r <= PTR_RST;
			wr_data_r <= BYTE_RST;
		end
		else if (adv_wr && isrp_valid(ptr_r))
		begin
			wr_tgl_r  <= ~wr_tgl_r;
			wr_addr_r <= ptr_r;
			wr_data_r <= shreg_r;
		end

	// Read request; a stale answer after an abort only clears the busy flag
	always_ff @(posedge lclk or negedge lrst_n_r)
		if (!lrst_n_r)
		begin
			rd_tgl_r  <= 1'b0;
			rd_addr_r <= PTR_RST;
			rd_busy_r <= 1'b0;
		end
		else if (rd_busy_r)
		begin
			if (ack_evt)
				rd_busy_r <= 1'b0;
		end
		else if (state_r == ST_FETCH)
		begin
			rd_tgl_r  <= ~rd_tgl_r;
			rd_addr_r <= ptr_r;
			rd_busy_r <= 1'b1;
		end

	assign sda_o  = 1'b0;
	assign sda_oe = oe_r;

	// System side: toggle synchronisers and register strobes
	always_ff @(posedge mclk or negedge mrst_n_r)
		if (!mrst_n_r)
		begin
			wr_s1_r <= 1'b0;
			wr_s2_r <= 1'b0;
			wr_q_r  <= 1'b0;
			rq_s1_r <= 1'b0;
			rq_s2_r <= 1'b0;
			rq_q_r  <= 1'b0;
		end
		else
		begin
			wr_s1_r <= wr_tgl_r;
			wr_s2_r <= wr_s1_r;
			wr_q_r  <= wr_s2_r;
			rq_s1_r <= rd_tgl_r;
			rq_s2_r <= rq_s1_r;
			rq_q_r  <= rq_s2_r;
		end

	always_ff @(posedge mclk or negedge mrst_n_r)
		if (!mrst_n_r)
		begin
			reg_wr_en   <= 1'b0;
			reg_wr_addr <= PTR_RST;
			reg_wr_data <= BYTE_RST;
		end
		else
		begin
			reg_wr_en <= wr_s2_r ^ wr_q_r;
			if (wr_s2_r ^ wr_q_r)
			begin
				reg_wr_addr <= wr_addr_r;
				reg_wr_data <= wr_data_r;
			end
		end

	always_ff @(posedge mclk or negedge mrst_n_r)
		if (!mrst_n_r)
		begin
			rd_pend_r   <= 1'b0;
			reg_rd_addr <= PTR_RST;
			rd_data_r   <= BYTE_RST;
			ack_tgl_r   <= 1'b0;
		end
		else if (rq_s2_r ^ rq_q_r)
		begin
			rd_pend_r   <= 1'b1;
			reg_rd_addr <= rd_addr_r;
		end
		else if (rd_pend_r)
		begin
			rd_pend_r <= 1'b0;
			rd_data_r <= reg_rd_data;
			ack_tgl_r <= ~ack_tgl_r;
		end

	assign reg_rd_en = rd_pend_r;

	// Checks
	a_start_detect: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(scl_f && pin_q_r[0] && pin_q_r[1] && !sda_f) |=> (state_r == ST_ADDR && bit_cnt_r == 4'h0))
		else $error("START not decoded");
	a_stop_detect: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(scl_f && pin_q_r[0] && !pin_q_r[1] && sda_f) |=> (state_r == ST_IDLE && !oe_r))
		else $error("STOP not decoded");
	a_hold_ptr: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(state_r == ST_RBYTE && isrp_hold(ptr_r)) |=> $stable(ptr_r))
		else $error("pointer moved on hold register read");
	a_invalid_wr: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(adv_wr && !isrp_valid(ptr_r)) |=> (!oe_r && ptr_r == $past(ptr_r) + 8'h01 && $stable(wr_tgl_r)))
		else $error("invalid write not refused or pointer stuck");
	a_valid_wr: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(adv_wr && isrp_valid(ptr_r)) |=> (oe_r && wr_addr_r == $past(ptr_r) && wr_data_r == $past(shreg_r)))
		else $error("valid write not stored");
	a_ptr_wrap: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		((adv_wr || adv_rd) && ptr_r == 8'hFF) |=> ptr_r == 8'h00)
		else $error("pointer did not wrap");
	a_sda_steady: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(state_r != ST_IDLE && $changed(oe_r) && !$past(start_c) && !$past(stop_c)) |-> !$past(scl_f))
		else $error("SDA changed while SCL high");
	a_addr_refuse: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(state_r == ST_ADDR && byte_end && !start_c && !stop_c && shreg_r[7:1] != DEV_ADDR)
		|=> (state_r == ST_IDLE && !oe_r))
		else $error("foreign address answered");
	a_nack_release: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(state_r == ST_RACK && rise && sda_f && !start_c && !stop_c) |=> (!oe_r && state_r == ST_IDLE)[*2])
		else $error("SDA not released after controller NACK");
	a_glitch_block: assert property (@(posedge lclk) disable iff (!lrst_n_r)
		(pin_s2_r[1] != pin_f_r[1] && filt_cnt_r[1] < 4'(FILT_CYC - 1)) |=> $stable(pin_f_r[1]))
		else $error("short SDA spike passed the filter");
	a_rd_answer: assert property (@(posedge mclk) disable iff (!mrst_n_r)
		(rq_s2_r ^ rq_q_r) |=> reg_rd_en ##1 (!reg_rd_en && rd_data_r == $past(reg_rd_data)))
		else $error("read answer not captured");

	c_write: cover property (@(posedge lclk) disable iff (!lrst_n_r) adv_wr && isrp_valid(ptr_r));
	c_read: cover property (@(posedge lclk) disable iff (!lrst_n_r) state_r == ST_RACK && rise && !sda_f);
	c_restart: cover property (@(posedge lclk) disable iff (!lrst_n_r) start_c && state_r != ST_IDLE);
	c_hold: cover property (@(posedge lclk) disable iff (!lrst_n_r) state_r == ST_RBYTE && isrp_hold(ptr_r));

endmodule // isrp_port

`default_nettype wire

// ==== hdl/isrp_pkg.sv ====
// Constants, states and address decode for the two-wire target register port
package isrp_pkg;

	// Target address and direction values
	localparam logic [6:0] DEV_ADDR   = 7'h36;
	localparam logic       DIR_WRITE  = 1'h0;
	localparam logic       DIR_READ   = 1'h1;

	// Bit positions and counts within one transfer unit
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam int         MSB_POS    = 7;

	// Registers whose high byte holds the pointer on reads
	localparam logic [7:0] RAW_POS_HI = 8'h0C;
	localparam logic [7:0] POS_HI     = 8'h0E;
	localparam logic [7:0] FIELD_HI   = 8'h1B;

	// Valid register address ranges
	localparam logic [7:0] CFG_FIRST  = 8'h00;
	localparam logic [7:0] CFG_LAST   = 8'h08;
	localparam logic [7:0] OUT_FIRST  = 8'h0B;
	localparam logic [7:0] OUT_LAST   = 8'h0F;
	localparam logic [7:0] STAT_FIRST = 8'h1A;
	localparam logic [7:0] STAT_LAST  = 8'h1C;
	localparam logic [7:0] CMD_ADDR   = 8'hFF;

	// Reset values
	localparam logic [7:0] PTR_RST    = 8'h00;
	localparam logic [7:0] BYTE_RST   = 8'h00;

	// Spike filter timing on the link clock
	localparam int         GLITCH_NS  = 50;
	localparam int         LCLK_NS    = 6;
	localparam int         FILT_CYC   = (GLITCH_NS + LCLK_NS - 1) / LCLK_NS;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_AACK  = 3'h2,
		ST_WBYTE = 3'h3,
		ST_WACK  = 3'h4,
		ST_FETCH = 3'h5,
		ST_RBYTE = 3'h6,
		ST_RACK  = 3'h7
	} isrp_state_t;

	function automatic logic isrp_valid(input logic [7:0] a);
		isrp_valid = (a <= CFG_LAST) || (a >= OUT_FIRST && a <= OUT_LAST) ||
			(a >= STAT_FIRST && a <= STAT_LAST) || (a == CMD_ADDR);
	endfunction

	function automatic logic isrp_hold(input logic [7:0] a);
		isrp_hold = (a == RAW_POS_HI) || (a == POS_HI) || (a == FIELD_HI);
	endfunction

endpackage

// ==== verif/isrp_host.sv ====
// Bus controller model: drives SCL and pulls SDA low
`timescale 1ns/1ns
`default_nettype none

module isrp_host
(
	// Timing reference
	input  wire logic clk,
	// Bus lines
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial
	begin
		scl = 1'h1;
		sda_low = 1'h0;
	end

	// Quarter bit; 500 ns low phase leaves room for the read fetch
	task automatic q();
		repeat (25) @(negedge clk);
	endtask

	// Also serves as repeated start from a held bus
	task automatic start();
		sda_low = 1'h0;
		q();
		scl = 1'h1;
		q();
		sda_low = 1'h1;
		q();
		scl = 1'h0;
		q();
	endtask

	task automatic stop();
		sda_low = 1'h1;
		q();
		scl = 1'h1;
		q();
		sda_low = 1'h0;
		q();
		q();
	endtask

	// Data changes only while SCL is low
	task automatic bit_x(input logic b, output logic r);
		sda_low = ~b;
		q();
		scl = 1'h1;
		q();
		r = sda;
		q();
		scl = 1'h0;
		q();
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'h1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'h1, d[i]);
		bit_x(~more, r);
	endtask

	// Short SDA spike on an idle bus, then SCL low without any condition
	task automatic glitch();
		sda_low = 1'h1;
		repeat (3) @(negedge clk);
		sda_low = 1'h0;
		q();
		scl = 1'h0;
		q();
	endtask
endmodule // isrp_host

`default_nettype wire

// ==== verif/tb_i2c_slave_register_port.sv ====
// Self-checking bench for the two-wire target register port
`timescale 1ns/1ns
`default_nettype none

module tb_i2c_slave_register_port
	import isrp_pkg::*;
;
	logic       mclk = 1'h0;
	logic       lclk = 1'h0;
	logic       rst_n;
	logic       scl;
	logic       h_low;
	logic       sda_o;
	logic       sda_oe;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic       rd_en;
	logic [7:0] rd_addr;
	logic [7:0] mem [256];
	logic [7:0] shadow [256];
	logic [7:0] ptr;
	int         n_errors;
	int         total_checks;
	int         cycles;
	wire logic  sda = ~h_low & (sda_oe ? sda_o : 1'b1);
	wire logic [7:0] rd_data = rd_en ? mem[rd_addr] : 8'h00;

	always #5 mclk = ~mclk;
	always #3 lclk = ~lclk;

	always @(posedge mclk)
		if (wr_en)
			mem[wr_addr] <= wr_data;

	isrp_host host (
		.clk     (mclk),
		.sda     (sda),
		.scl     (scl),
		.sda_low (h_low)
	);

	isrp_port dut (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.lclk        (lclk),
		.scl_i       (scl),
		.sda_i       (sda),
		.sda_o       (sda_o),
		.sda_oe      (sda_oe),
		.reg_wr_en   (wr_en),
		.reg_wr_addr (wr_addr),
		.reg_wr_data (wr_data),
		.reg_rd_en   (rd_en),
		.reg_rd_addr (rd_addr),
		.reg_rd_data (rd_data)
	);

	function automatic logic vld(input logic [7:0] a);
		return a <= CFG_LAST || (a >= OUT_FIRST && a <= OUT_LAST) ||
			(a >= STAT_FIRST && a <= STAT_LAST) || a == CMD_ADDR;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
			n_errors++;
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic do_write(input logic [7:0] p, input int n, input logic [7:0] d0);
		logic       ack;
		logic [7:0] a;
		a = p;
		host.start();
		host.wbyte({DEV_ADDR, DIR_WRITE}, ack);
		chk({7'h0, ack}, 8'h01, "write address ack");
		host.wbyte(p, ack);
		chk({7'h0, ack}, {7'h0, vld(p)}, "pointer ack");
		for (int k = 0; k < n; k++)
		begin
			host.wbyte(d0 + 8'(k), ack);
			chk({7'h0, ack}, {7'h0, vld(a)}, "data ack");
			if (vld(a))
				shadow[a] = d0 + 8'(k);
			a++;
		end
		host.stop();
		for (int k = 0; k < n; k++)
			chk(mem[p + 8'(k)], shadow[p + 8'(k)], "stored byte");
		ptr = a;
	endtask

	task automatic do_read(input logic setp, input logic [7:0] p, input int n);
		logic       ack;
		logic [7:0] d;
		if (setp)
		begin
			host.start();
			host.wbyte({DEV_ADDR, DIR_WRITE}, ack);
			host.wbyte(p, ack);
			ptr = p;
		end
		host.start();
		host.wbyte({DEV_ADDR, DIR_READ}, ack);
		chk({7'h0, ack}, 8'h01, "read address ack");
		for (int k = 0; k < n; k++)
		begin
			host.rbyte(k < n - 1, d);
			chk(d, vld(ptr) ? shadow[ptr] : 8'h00, "read byte");
			if (ptr != RAW_POS_HI && ptr != POS_HI && ptr != FIELD_HI)
				ptr++;
		end
		host.stop();
	endtask

	task automatic t_page_write();
		do_write(8'h07, 5, 8'h50);
	endtask

	task automatic t_wrap_write();
		do_write(8'hF8, 12, 8'h90);
	endtask

	task automatic t_hold_read();
		do_read(1'h1, 8'h0A, 4);
		do_read(1'h1, 8'h1A, 4);
	endtask

	task automatic t_wrap_read();
		do_read(1'h1, 8'hFE, 4);
		do_read(1'h0, 8'h00, 3);
	endtask

	task automatic t_foreign();
		logic       ack;
		logic [6:0] other [3] = '{7'h37, 7'h1B, 7'h76};
		for (int i = 0; i < 3; i++)
		begin
			host.start();
			host.wbyte({other[i], DIR_WRITE}, ack);
			chk({7'h0, ack}, 8'h00, "foreign address ack");
			host.stop();
		end
	endtask

	task automatic t_spike();
		logic ack;
		host.glitch();
		host.wbyte({DEV_ADDR, DIR_WRITE}, ack);
		chk({7'h0, ack}, 8'h00, "ack after spike");
		host.stop();
		do_read(1'h0, 8'h00, 2);
	endtask

	always @(posedge mclk)
	begin
		cycles = cycles + 1;
		if (cycles == 70000)
		begin
			$display("unexpected at %0t: run hung", $time);
			n_errors = n_errors + 1;
			report_and_stop();
		end
	end

	initial
	begin
		rst_n = 1'h0;
		n_errors = 0;
		total_checks = 0;
		cycles = 0;
		ptr = PTR_RST;
		for (int i = 0; i < 256; i++)
		begin
			mem[i] = 8'(i) ^ 8'hA5;
			shadow[i] = 8'(i) ^ 8'hA5;
		end
		repeat (5) @(negedge mclk);
		rst_n = 1'h1;
		repeat (30) @(negedge mclk);
		t_page_write();
		t_wrap_write();
		t_hold_read();
		t_wrap_read();
		t_foreign();
		t_spike();
		report_and_stop();
	end
endmodule // tb_i2c_slave_register_port

`default_nettype wire
